//--- fard_cfg.svh
// Constants for the fuel/air record sender: byte positions, codes and timing
// Summary of operation
// (R1) Byte 93: drift digit sum, letter excluded
// (R2) Bytes 94-98: altitude rate digits, then sign
// (R3) Byte 99: rate digit sum, sign excluded
// (R4) Bytes 100-102 heading digits, 103 their sum
// (R5) Bytes 104-106 temperature, sign; 107 sum
// (R6) Third format ends with 03h at 108
// (R7) Fourth format: 121 bytes, optional fuel asterisks
// (R8) Bytes 108-112 baro setting, hundredths first
// (R9) Byte 113: low BCD digit of baro sum
// (R10) Bytes 114-119 corrected altitude; 120 digit sum
// (R11) Fourth format ends with 03h at 121
// (R12) Fuel-only receiver uses fuel fields, no error
// (R13) Air-only receiver uses air fields, no error
// (R14) Air-only receiver flags first/second formats
// (R15) Nothing configured, no input: flag shown
// (R16) Sender sends one record every 1.6 s
// (R17) Receiver invalidates data after 4.0 s silence
// (R18) Digit checksum: low BCD digit of sum
// (R19) Numeric fields go units digit first
// (R20) Receiver drops records with bad checks
`ifndef FARD_CFG_SVH
`define FARD_CFG_SVH

`define FARD_CLK_KHZ 200000
`define FARD_INTERVAL_MS 1600
`define FARD_POS_W 7
`define FARD_HEAD_LEN 7'd89
`define FARD_POS_FIRST 7'd1
`define FARD_POS_FUELNA_LO 7'd3
`define FARD_POS_FUELNA_HI 7'd9
`define FARD_POS_DRIFT 7'd90
`define FARD_POS_DRIFT_CK 7'd93
`define FARD_POS_RATE 7'd94
`define FARD_POS_RATE_CK 7'd99
`define FARD_POS_HDG 7'd100
`define FARD_POS_HDG_CK 7'd103
`define FARD_POS_SAT 7'd104
`define FARD_POS_SAT_CK 7'd107
`define FARD_POS_END_C 7'd108
`define FARD_POS_BARO 7'd108
`define FARD_POS_BARO_CK 7'd113
`define FARD_POS_BALT 7'd114
`define FARD_POS_BALT_CK 7'd120
`define FARD_POS_END_D 7'd121
`define FARD_ASC_ETX 8'h03
`define FARD_ASC_STAR 8'h2a
`define FARD_ASC_PLUS 8'h2b
`define FARD_ASC_MINUS 8'h2d
`define FARD_ASC_DOT 8'h2e
`define FARD_ASC_ZERO 8'h30
`define FARD_ASC_NINE 8'h39
`define FARD_ASC_LEFT 8'h4c
`define FARD_ASC_RIGHT 8'h52

`endif

//--- fard_pkg.sv
// Types shared by the fuel/air record sender
package fard_pkg;
   typedef enum logic {FARD_IDLE, FARD_SEND} fard_state_e;

   typedef struct packed {
      logic fmt_d;
      logic fuel_na;
      logic [7:0] drift_dig;
      logic drift_right;
      logic [15:0] rate_dig;
      logic rate_neg;
      logic [11:0] hdg_dig;
      logic [7:0] sat_dig;
      logic sat_neg;
      logic [15:0] baro_dig;
      logic [19:0] balt_dig;
      logic balt_neg;
   } fard_fields_s;
endpackage

//--- fard_tick.sv
// Free-running record interval timer
module fard_tick #(
   parameter int unsigned CYCLES = 320000000
) (
   input wire logic mclk,
   input wire logic rst_b,
   input wire logic run,
   output logic tick
);
   logic [31:0] cnt_reg;
   logic [31:0] cnt_next;
   logic tick_reg;
   logic tick_next;

   always_comb begin
      cnt_next = 32'h0;
      tick_next = 1'b0;
      if (run) begin
         if (cnt_reg >= CYCLES - 32'h1) begin
            tick_next = 1'b1; // R16
         end else begin
            cnt_next = cnt_reg + 32'h1;
         end
      end
   end

   always_ff @(posedge mclk or negedge rst_b) begin
      if (!rst_b) begin
         cnt_reg <= 32'h0;
         tick_reg <= 1'b0;
      end else begin
         cnt_reg <= cnt_next;
         tick_reg <= tick_next;
      end
   end

   assign tick = tick_reg;
endmodule // fard_tick

//--- fard_csum.sv
// Running decimal digit sum kept modulo ten
`include "fard_cfg.svh"
module fard_csum (
   input wire logic [3:0] acc,
   input wire logic [7:0] data,
   output logic [3:0] sum
);
   logic [4:0] t;

   always_comb begin
      t = {1'b0, acc};
      // Sign, direction, point and asterisk bytes fall outside the digit range
      if (data >= `FARD_ASC_ZERO && data <= `FARD_ASC_NINE) begin
         t = {1'b0, acc} + {1'b0, data[3:0]};
      end
      sum = (t >= 5'd10) ? 4'(t - 5'd10) : t[3:0]; // R18
   end
endmodule // fard_csum

//--- fard_sender.sv
// Sender of third and fourth format fuel/air records as a byte stream
`include "fard_cfg.svh"
module fard_sender #(
   parameter int unsigned INTERVAL_CYC = `FARD_INTERVAL_MS * `FARD_CLK_KHZ
) (
   input wire logic mclk,
   input wire logic rst_b,
   input wire logic run,
   input wire logic send_now,
   input wire logic fmt_d,
   input wire logic fuel_na,
   input wire logic head_we,
   input wire logic [6:0] head_idx,
   input wire logic [7:0] head_data,
   input wire logic [7:0] drift_dig,
   input wire logic drift_right,
   input wire logic [15:0] rate_dig,
   input wire logic rate_neg,
   input wire logic [11:0] hdg_dig,
   input wire logic [7:0] sat_dig,
   input wire logic sat_neg,
   input wire logic [15:0] baro_dig,
   input wire logic [19:0] balt_dig,
   input wire logic balt_neg,
   input wire logic tx_ready,
   output logic [7:0] tx_data,
   output logic tx_valid,
   output logic busy,
   output logic rec_done
);
   import fard_pkg::*;

   logic [7:0] head_mem [1:89];

   fard_state_e state_reg;
   fard_state_e state_next;
   fard_fields_s snap_reg;
   fard_fields_s snap_next;
   fard_fields_s snap_in;
   fard_fields_s bsnap;
   logic [6:0] pos_reg;
   logic [6:0] pos_next;
   logic [6:0] bpos;
   logic [3:0] acc_reg;
   logic [3:0] acc_next;
   logic [3:0] csum;
   logic [7:0] tx_data_reg;
   logic [7:0] tx_data_next;
   logic tx_valid_reg;
   logic tx_valid_next;
   logic busy_reg;
   logic busy_next;
   logic done_reg;
   logic done_next;
   logic [7:0] nb;
   logic tick;
   logic start;
   logic take;
   logic [6:0] last_pos;

   function automatic logic [7:0] asc(input logic [3:0] d);
      return {4'h3, d};
   endfunction

   function automatic logic [7:0] sign_byte(input logic neg);
      return neg ? `FARD_ASC_MINUS : `FARD_ASC_PLUS;
   endfunction

   function automatic logic is_csum_pos(input logic [6:0] p);
      return (p == `FARD_POS_DRIFT_CK) || (p == `FARD_POS_RATE_CK) || (p == `FARD_POS_HDG_CK) ||
             (p == `FARD_POS_SAT_CK) || (p == `FARD_POS_BARO_CK) || (p == `FARD_POS_BALT_CK);
   endfunction

   fard_tick #(
      .CYCLES(INTERVAL_CYC)
   ) u_tick (
      .mclk(mclk),
      .rst_b(rst_b),
      .run(run),
      .tick(tick)
   );

   fard_csum u_csum (
      .acc(acc_reg),
      .data(tx_data_reg),
      .sum(csum)
   );

   // Header bytes of the record are loaded by the user and sent verbatim, except bytes 3-9, which are asterisks in fourth format with fuel_na set
   always_ff @(posedge mclk) begin
      if (head_we && head_idx >= `FARD_POS_FIRST && head_idx <= `FARD_HEAD_LEN) begin
         head_mem[head_idx] <= head_data;
      end
   end

   always_comb begin
      snap_in.fmt_d = fmt_d;
      snap_in.fuel_na = fuel_na;
      snap_in.drift_dig = drift_dig;
      snap_in.drift_right = drift_right;
      snap_in.rate_dig = rate_dig;
      snap_in.rate_neg = rate_neg;
      snap_in.hdg_dig = hdg_dig;
      snap_in.sat_dig = sat_dig;
      snap_in.sat_neg = sat_neg;
      snap_in.baro_dig = baro_dig;
      snap_in.balt_dig = balt_dig;
      snap_in.balt_neg = balt_neg;
   end

   assign start = (state_reg == FARD_IDLE) && run && (tick || send_now);
   assign take = tx_valid_reg && tx_ready;
   assign last_pos = snap_reg.fmt_d ? `FARD_POS_END_D : `FARD_POS_END_C; // R6 R11
   // Fields are frozen at record start so a record never mixes two updates
   assign bpos = start ? `FARD_POS_FIRST : 7'(pos_reg + 7'd1);
   assign bsnap = start ? snap_in : snap_reg;

   // Byte at position bpos; checksum positions are filled from the running sum instead
   always_comb begin
      nb = `FARD_ASC_ETX;
      if (bpos <= `FARD_HEAD_LEN) begin
         nb = head_mem[bpos];
         if (bsnap.fmt_d && bsnap.fuel_na && bpos >= `FARD_POS_FUELNA_LO && bpos <= `FARD_POS_FUELNA_HI) begin
            nb = `FARD_ASC_STAR; // R7
         end
      end else begin
         case (bpos)
            7'd90: nb = asc(bsnap.drift_dig[3:0]); // R19
            7'd91: nb = asc(bsnap.drift_dig[7:4]);
            7'd92: nb = bsnap.drift_right ? `FARD_ASC_RIGHT : `FARD_ASC_LEFT;
            7'd94: nb = asc(bsnap.rate_dig[3:0]); // R2
            7'd95: nb = asc(bsnap.rate_dig[7:4]);
            7'd96: nb = asc(bsnap.rate_dig[11:8]);
            7'd97: nb = asc(bsnap.rate_dig[15:12]);
            7'd98: nb = sign_byte(bsnap.rate_neg);
            7'd100: nb = asc(bsnap.hdg_dig[3:0]); // R4
            7'd101: nb = asc(bsnap.hdg_dig[7:4]);
            7'd102: nb = asc(bsnap.hdg_dig[11:8]);
            7'd104: nb = asc(bsnap.sat_dig[3:0]); // R5
            7'd105: nb = asc(bsnap.sat_dig[7:4]);
            7'd106: nb = sign_byte(bsnap.sat_neg);
            7'd108: nb = bsnap.fmt_d ? asc(bsnap.baro_dig[3:0]) : `FARD_ASC_ETX; // R6 R8
            7'd109: nb = asc(bsnap.baro_dig[7:4]);
            7'd110: nb = `FARD_ASC_DOT;
            7'd111: nb = asc(bsnap.baro_dig[11:8]);
            7'd112: nb = asc(bsnap.baro_dig[15:12]);
            7'd114: nb = asc(bsnap.balt_dig[3:0]); // R10
            7'd115: nb = asc(bsnap.balt_dig[7:4]);
            7'd116: nb = asc(bsnap.balt_dig[11:8]);
            7'd117: nb = asc(bsnap.balt_dig[15:12]);
            7'd118: nb = asc(bsnap.balt_dig[19:16]);
            7'd119: nb = sign_byte(bsnap.balt_neg);
            7'd121: nb = `FARD_ASC_ETX; // R11
            default: nb = `FARD_ASC_ETX;
         endcase
      end
   end

   always_comb begin
      state_next = state_reg;
      snap_next = snap_reg;
      pos_next = pos_reg;
      acc_next = acc_reg;
      tx_data_next = tx_data_reg;
      tx_valid_next = tx_valid_reg;
      busy_next = busy_reg;
      done_next = 1'b0;
      case (state_reg)
         FARD_IDLE: begin
            if (start) begin
               state_next = FARD_SEND;
               snap_next = snap_in;
               pos_next = `FARD_POS_FIRST;
               acc_next = 4'h0;
               tx_data_next = nb;
               tx_valid_next = 1'b1;
               busy_next = 1'b1;
            end
         end
         FARD_SEND: begin
            if (take) begin
               if (pos_reg == last_pos) begin
                  state_next = FARD_IDLE;
                  tx_valid_next = 1'b0;
                  busy_next = 1'b0;
                  done_next = 1'b1;
               end else begin
                  pos_next = 7'(pos_reg + 7'd1);
                  if (is_csum_pos(bpos)) begin
                     // Sum covers only digits since the previous checksum
                     tx_data_next = asc(csum); // R1 R3 R4 R5 R9 R10
                     acc_next = 4'h0;
                  end else begin
                     tx_data_next = nb;
                     // A checksum byte is itself a digit and must not seed the next field's sum
                     acc_next = (pos_reg >= `FARD_POS_DRIFT && !is_csum_pos(pos_reg)) ? csum : 4'h0;
                  end
               end
            end
         end
         default: begin
            state_next = FARD_IDLE;
            tx_valid_next = 1'b0;
            busy_next = 1'b0;
         end
      endcase
   end

   always_ff @(posedge mclk or negedge rst_b) begin
      if (!rst_b) begin
         state_reg <= FARD_IDLE;
         snap_reg <= '0;
         pos_reg <= 7'h0;
         acc_reg <= 4'h0;
         tx_data_reg <= 8'h00;
         tx_valid_reg <= 1'b0;
         busy_reg <= 1'b0;
         done_reg <= 1'b0;
      end else begin
         state_reg <= state_next;
         snap_reg <= snap_next;
         pos_reg <= pos_next;
         acc_reg <= acc_next;
         tx_data_reg <= tx_data_next;
         tx_valid_reg <= tx_valid_next;
         busy_reg <= busy_next;
         done_reg <= done_next;
      end
   end

   assign tx_data = tx_data_reg;
   assign tx_valid = tx_valid_reg;
   assign busy = busy_reg;
   assign rec_done = done_reg;
endmodule // fard_sender

//--- fard_sender_asserts.sv
// Checker for the record sender byte stream
module fard_sender_asserts (
   input wire logic mclk,
   input wire logic rst_b,
   input wire logic tx_ready,
   input wire logic [7:0] tx_data,
   input wire logic tx_valid,
   input wire logic rec_done
);
   timeunit 1ns;
   timeprecision 1ps;
   logic [6:0] pos_reg;
   logic [6:0] pos_next;
   default clocking @(posedge mclk); endclocking
   default disable iff (!rst_b);
   // Bytes taken so far in the current record
   always_comb begin
      pos_next = pos_reg;
      if (rec_done) pos_next = 7'h0;
      else if (tx_valid && tx_ready) pos_next = pos_reg + 7'h1;
   end
   always_ff @(posedge mclk or negedge rst_b) begin
      if (!rst_b) pos_reg <= 7'h0;
      else pos_reg <= pos_next;
   end
   property p_len; rec_done |-> pos_reg == 7'd108 || pos_reg == 7'd121; endproperty
   a_len: assert property (p_len) else $error("record length wrong");
   property p_etx; rec_done |-> $past(tx_data) == 8'h03; endproperty
   a_etx: assert property (p_etx) else $error("last byte not end code");
   property p_dir; tx_valid && pos_reg == 7'd91 |-> tx_data inside {8'h4c, 8'h52}; endproperty
   a_dir: assert property (p_dir) else $error("drift letter wrong");
   property p_rsign; tx_valid && pos_reg == 7'd97 |-> tx_data inside {8'h2b, 8'h2d}; endproperty
   a_rsign: assert property (p_rsign) else $error("rate sign wrong");
   property p_ssign; tx_valid && pos_reg == 7'd105 |-> tx_data inside {8'h2b, 8'h2d}; endproperty
   a_ssign: assert property (p_ssign) else $error("temperature sign wrong");
   property p_dot; tx_valid && pos_reg == 7'd109 |-> tx_data == 8'h2e; endproperty
   a_dot: assert property (p_dot) else $error("baro point wrong");
   property p_bsign; tx_valid && pos_reg == 7'd118 |-> tx_data inside {8'h2b, 8'h2d}; endproperty
   a_bsign: assert property (p_bsign) else $error("altitude sign wrong");
   property p_dig;
      tx_valid && pos_reg inside {[89:90], [92:96], [98:104], 106} |-> tx_data inside {[8'h30:8'h39]};
   endproperty
   a_dig: assert property (p_dig) else $error("digit byte out of range");
   c_long: cover property (rec_done && pos_reg == 7'd121);
   c_short: cover property (rec_done && pos_reg == 7'd108);
   c_stall: cover property (tx_valid && !tx_ready);
endmodule // fard_sender_asserts

bind fard_sender fard_sender_asserts u_asserts (.mclk, .rst_b, .tx_ready, .tx_data, .tx_valid, .rec_done);

//--- fard_rx_model.sv
// Receiving device model: paces the byte stream and keeps every byte it takes
module fard_rx_model #(
   parameter int WD = 800
) (
   input wire logic mclk,
   input wire logic rst_b,
   input wire logic slow,
   input wire logic [7:0] tx_data,
   input wire logic tx_valid,
   output logic tx_ready = 1'b1,
   output logic data_ok
);
   timeunit 1ns;
   timeprecision 1ps;
   logic [7:0] got[$];
   logic [1:0] ph = 2'h0;
   int idle;
   logic in_err;
   logic no_input;
   // Every digit checksum from byte 90 on must match the digits since the previous one
   function automatic bit sums_ok();
      int s;
      s = 0;
      for (int p = 90; p < got.size(); p++) begin
         if (p inside {93, 99, 103, 107, 113, 120}) begin
            if (got[p - 1] != 8'h30 + 8'(s % 10)) return 1'b0;
            s = 0;
         end else if (got[p - 1] inside {[8'h30:8'h39]}) begin
            s += int'(got[p - 1] - 8'h30);
         end
      end
      return 1'b1;
   endfunction
   // Slow mode refuses one byte slot in four
   always @(negedge mclk) begin
      ph <= ph + 2'h1;
      tx_ready <= !slow || ph != 2'h0;
   end
   always @(posedge mclk or negedge rst_b) begin
      if (!rst_b) begin
         data_ok <= 1'b0;
         in_err <= 1'b0;
         no_input <= 1'b1;
         idle <= 0;
      end else begin
         idle <= idle + 1;
         if (idle >= WD) begin
            data_ok <= 1'b0;
            no_input <= 1'b1;
         end
         if (tx_valid && tx_ready) begin
            got.push_back(tx_data);
            if (tx_data == 8'h03) begin
               // Set up for air data: third and fourth formats are used, shorter ones flagged
               in_err <= !(got.size() == 108 || got.size() == 121);
               no_input <= 1'b0;
            end
            if (tx_data == 8'h03 && (got.size() == 108 || got.size() == 121) && sums_ok()) begin
               data_ok <= 1'b1;
               idle <= 0;
            end
         end
      end
   end
endmodule // fard_rx_model

//--- fard_sender_tb.sv
// Self-checking bench for the record sender
module fard_sender_tb;
   timeunit 1ns;
   timeprecision 1ps;
   localparam int IV = 2000;
   // Invalidation after 4.0 s against the 1.6 s record interval
   localparam int WD = IV * 5 / 2;
   logic mclk = 0, rst_b = 0, run = 0, send_now = 0, fmt_d = 0, fuel_na = 0, head_we = 0, slow = 0;
   logic drift_right = 0, rate_neg = 0, sat_neg = 0, balt_neg = 0;
   logic [6:0] head_idx = 0;
   logic [7:0] head_data = 0, drift_dig = 0, sat_dig = 0, tx_data;
   logic [15:0] rate_dig = 0, baro_dig = 0;
   logic [11:0] hdg_dig = 0;
   logic [19:0] balt_dig = 0;
   logic tx_ready, tx_valid, busy, rec_done, data_ok;
   logic [31:0] seed = 32'he4676668;
   logic [7:0] head[1:89];
   logic [7:0] exp_q[$];
   int mismatches = 0, checks = 0, sum, n;
   initial forever #2.5 mclk = ~mclk;
   fard_sender #(.INTERVAL_CYC(IV)) u_dut (.mclk, .rst_b, .run, .send_now, .fmt_d, .fuel_na, .head_we,
      .head_idx, .head_data, .drift_dig, .drift_right, .rate_dig, .rate_neg, .hdg_dig, .sat_dig, .sat_neg,
      .baro_dig, .balt_dig, .balt_neg, .tx_ready, .tx_data, .tx_valid, .busy, .rec_done);
   fard_rx_model #(.WD(WD)) u_rx (.mclk, .rst_b, .slow, .tx_data, .tx_valid, .tx_ready, .data_ok);
   function automatic logic [31:0] rnd();
      seed ^= seed << 13;
      seed ^= seed >> 17;
      seed ^= seed << 5;
      return seed;
   endfunction
   function automatic logic [19:0] bcd();
      logic [19:0] v;
      for (int j = 0; j < 5; j++) v[4*j+:4] = 4'(rnd() % 10);
      return v;
   endfunction
   task automatic dig(input logic [19:0] v, input int k);
      for (int j = 0; j < k; j++) begin
         exp_q.push_back(8'h30 + 8'(v[4*j+:4]));
         sum += v[4*j+:4];
      end
   endtask
   task automatic ck();
      exp_q.push_back(8'h30 + 8'(sum % 10));
      sum = 0;
   endtask
   task automatic sgn(input logic neg);
      exp_q.push_back(neg ? 8'h2d : 8'h2b);
   endtask
   // Reference record, units digit first in every field
   task automatic build();
      exp_q.delete();
      sum = 0;
      for (int i = 1; i <= 89; i++) exp_q.push_back((fmt_d && fuel_na && i >= 3 && i <= 9) ? 8'h2a : head[i]);
      dig(20'(drift_dig), 2);
      exp_q.push_back(drift_right ? 8'h52 : 8'h4c);
      ck();
      dig(20'(rate_dig), 4);
      sgn(rate_neg);
      ck();
      dig(20'(hdg_dig), 3);
      ck();
      dig(20'(sat_dig), 2);
      sgn(sat_neg);
      ck();
      if (fmt_d) begin
         dig(20'(baro_dig[7:0]), 2);
         exp_q.push_back(8'h2e);
         dig(20'(baro_dig[15:8]), 2);
         ck();
         dig(balt_dig, 5);
         sgn(balt_neg);
         ck();
      end
      exp_q.push_back(8'h03);
   endtask
   task automatic cmp(input string what, input logic [31:0] e, input logic [31:0] s);
      checks++;
      if (e !== s) begin
         mismatches++;
         $display("mismatch %s expected %h seen %h", what, e, s);
      end
   endtask
   task automatic wrap_up();
      if (mismatches == 0 && checks > 0) $display("TEST PASSED");
      else $display("TEST FAILED");
      $finish;
   endtask
   task automatic check_rec();
      n = 0;
      while (rec_done !== 1'b1) begin
         @(negedge mclk);
         n++;
         if (n > 3000) begin
            cmp("rec_done", 1, 0);
            wrap_up();
         end
      end
      cmp("length", exp_q.size(), u_rx.got.size());
      foreach (exp_q[i]) cmp($sformatf("byte %0d", i + 1), exp_q[i], u_rx.got[i]);
      cmp("accepted", 1, data_ok);
      cmp("input error", 0, u_rx.in_err);
      cmp("busy after record", 0, busy);
   endtask
   initial begin
      repeat (6) @(negedge mclk);
      rst_b = 1;
      cmp("no input before first record", 1, u_rx.no_input);
      for (int i = 1; i <= 89; i++) begin
         @(negedge mclk);
         head_we = 1;
         head_idx = 7'(i);
         head_data = 8'h30 + 8'(rnd() % 10);
         head[i] = head_data;
      end
      @(negedge mclk);
      head_we = 0;
      for (int k = 0; k < 6; k++) begin
         fmt_d = k[0];
         fuel_na = k[1];
         slow = k[2];
         {drift_right, rate_neg, sat_neg, balt_neg} = 4'(rnd());
         drift_dig = 8'(bcd());
         rate_dig = 16'(bcd());
         hdg_dig = 12'(bcd());
         sat_dig = 8'(bcd());
         baro_dig = 16'(bcd());
         balt_dig = (k == 5) ? 20'h99999 : bcd();
         build();
         u_rx.got.delete();
         run = 0;
         @(negedge mclk);
         run = 1;
         send_now = 1;
         @(negedge mclk);
         send_now = 0;
         // A second start while busy must be dropped
         repeat (20) @(negedge mclk);
         cmp("busy during record", 1, busy);
         send_now = 1;
         @(negedge mclk);
         send_now = 0;
         check_rec();
         repeat (5) @(negedge mclk);
         cmp("idle after record", 0, tx_valid);
      end
      u_rx.got.delete();
      run = 0;
      @(negedge mclk);
      run = 1;
      n = 0;
      while (tx_valid !== 1'b1 && n < IV + 10) begin
         @(negedge mclk);
         n++;
      end
      cmp("interval", 1, 32'(n >= IV && n <= IV + 3));
      cmp("data kept over one interval", 1, data_ok);
      check_rec();
      run = 0;
      repeat (WD - 10) @(negedge mclk);
      cmp("data kept in grace time", 1, data_ok);
      repeat (20) @(negedge mclk);
      cmp("stale data dropped", 0, data_ok);
      cmp("no input after silence", 1, u_rx.no_input);
      wrap_up();
   end
endmodule // fard_sender_tb
